// ==== hdl/twm_defs.svh ====
// Offsets, field positions, reset values and timing counts of the controller
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH
// System clock rate and bus rates in kbps
`define TWM_CLK_KHZ 100000
`define TWM_KBPS_100 100
`define TWM_KBPS_250 250
`define TWM_KBPS_400 400
`define TWM_KBPS_1000 1000
// Quarter bit period in clock cycles, rounded down
`define TWM_QCNT(kbps) (`TWM_CLK_KHZ / (4 * (kbps)))
// Rate select codes
`define TWM_FREQ_100 2'h0
`define TWM_FREQ_250 2'h1
`define TWM_FREQ_400 2'h2
`define TWM_FREQ_1000 2'h3
// Register byte offsets
`define TWM_OFS_TASK_RD 12'h000
`define TWM_OFS_TASK_WR 12'h008
`define TWM_OFS_TASK_STOP 12'h014
`define TWM_OFS_TASK_SUSP 12'h01c
`define TWM_OFS_TASK_RES 12'h020
`define TWM_OFS_EV_STOPPED 12'h104
`define TWM_OFS_EV_ERROR 12'h124
`define TWM_OFS_EV_SUSP 12'h148
`define TWM_OFS_EV_RXB 12'h14c
`define TWM_OFS_EV_TXB 12'h150
`define TWM_OFS_EV_LRX 12'h15c
`define TWM_OFS_EV_LTX 12'h160
`define TWM_OFS_SHORTS 12'h200
`define TWM_OFS_ERRSRC 12'h4c4
`define TWM_OFS_ENABLE 12'h500
`define TWM_OFS_FREQ 12'h524
`define TWM_OFS_RXPTR 12'h534
`define TWM_OFS_RXMAX 12'h538
`define TWM_OFS_RXAMT 12'h53c
`define TWM_OFS_TXPTR 12'h544
`define TWM_OFS_TXMAX 12'h548
`define TWM_OFS_TXAMT 12'h54c
`define TWM_OFS_ADDR 12'h588
// Event bit positions
`define TWM_EV_STOPPED 0
`define TWM_EV_ERROR 1
`define TWM_EV_SUSP 2
`define TWM_EV_RXB 3
`define TWM_EV_TXB 4
`define TWM_EV_LRX 5
`define TWM_EV_LTX 6
// Task bit positions
`define TWM_TK_RD 0
`define TWM_TK_WR 1
`define TWM_TK_STOP 2
`define TWM_TK_SUSP 3
`define TWM_TK_RES 4
// Shortcut bit positions
`define TWM_SH_LTX_RD 0
`define TWM_SH_LTX_STOP 1
`define TWM_SH_LRX_WR 2
`define TWM_SH_LRX_STOP 3
// Error source bit positions
`define TWM_ERR_ANACK 1
`define TWM_ERR_DNACK 2
// Reset values
`define TWM_RST_FREQ 2'h0
`define TWM_RST_WORD 32'h0000_0000
`endif

// ==== hdl/twm_pkg.sv ====
// Types shared by the two-wire master controller
package twm_pkg;
  // Sequencer states
  typedef enum {
    ST_IDLE, ST_START, ST_BIT, ST_HOLD, ST_SUSP, ST_STOP
  } twm_state_e;
  // Byte-wide memory request of the buffer channels
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } twm_dma_s;
endpackage : twm_pkg

// ==== hdl/twm_two_wire_master.sv ====
// Two-wire master with buffer channels, APB registers and task inputs
`include "twm_defs.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Bus rate 100, 250, 400 or 1000 kbps
// - Sole master, no arbitration, 7-bit address
// - Wait while slave stretches SCL low
// - Start tasks begin, stop halts, stopped event
// - Suspend after byte, hold SCL, suspended event
// - No stop while suspended; resume first
// - NACK in acknowledge slot raises error event
// - Write channel fetches, read channel stores bytes
// - Pointers and counts shadowed until next start
// - Stopped only after memory accesses finish
// - Write: start, address, bit 0, sample ACK
// - Send buffer bytes, sample ACK after each
// - Final send event when last byte begins
// - Never stops by itself; stop task needed
// - Read: start, address, bit 1, sample ACK
// - Store bytes; ACK all but last, NACK last
// - Final receive event timing by count
// - Repeated start between write and read
module twm_two_wire_master (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Event interconnect
  input wire logic [4:0] task_i,
  output logic [6:0] event_o,
  // Buffer memory port
  output twm_pkg::twm_dma_s dma_o,
  input wire logic [7:0] dma_rdata_i,
  input wire logic dma_ack_i,
  // Bus lines, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);
  twm_pkg::twm_state_e state;
  logic scl_s1, scl_s2, sda_s1, sda_s2;
  logic [1:0] ph;
  logic [7:0] qcnt, qload;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic is_rd, addr_ph, rx_store;
  logic [15:0] cnt, max_act;
  logic [31:0] ptr_act;
  logic rd_p, wr_p, stop_p, susp_p;
  logic [6:0] evr, ev_p;
  logic [3:0] shorts;
  logic [2:0] errsrc;
  logic enable;
  logic [1:0] freq;
  logic [6:0] saddr;
  logic [31:0] rx_ptr, tx_ptr;
  logic [15:0] rx_max, tx_max, rx_amt, tx_amt;
  logic [4:0] tk;
  logic wr_en, stretch, tick, busy, take;
  logic [31:0] next_rdata;
  logic next_err;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task collection from APB, interconnect and shortcuts
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  always_comb begin
    tk = task_i;
    if (wr_en && pwdata_i[0]) begin
      if (paddr_i == `TWM_OFS_TASK_RD) tk[`TWM_TK_RD] = 1'b1;
      else if (paddr_i == `TWM_OFS_TASK_WR) tk[`TWM_TK_WR] = 1'b1;
      else if (paddr_i == `TWM_OFS_TASK_STOP) tk[`TWM_TK_STOP] = 1'b1;
      else if (paddr_i == `TWM_OFS_TASK_SUSP) tk[`TWM_TK_SUSP] = 1'b1;
      else if (paddr_i == `TWM_OFS_TASK_RES) tk[`TWM_TK_RES] = 1'b1;
    end
    // Shortcuts chain the final byte events into tasks
    if (shorts[`TWM_SH_LTX_RD] && event_o[`TWM_EV_LTX])
      tk[`TWM_TK_RD] = 1'b1;
    if (shorts[`TWM_SH_LTX_STOP] && event_o[`TWM_EV_LTX])
      tk[`TWM_TK_STOP] = 1'b1;
    if (shorts[`TWM_SH_LRX_WR] && event_o[`TWM_EV_LRX])
      tk[`TWM_TK_WR] = 1'b1;
    if (shorts[`TWM_SH_LRX_STOP] && event_o[`TWM_EV_LRX])
      tk[`TWM_TK_STOP] = 1'b1;
    if (!enable) tk = 5'h00;
  end

  // Quarter bit period per selected rate
  always_comb begin
    case (freq)
      `TWM_FREQ_100: qload = 8'(`TWM_QCNT(`TWM_KBPS_100) - 1);
      `TWM_FREQ_250: qload = 8'(`TWM_QCNT(`TWM_KBPS_250) - 1);
      `TWM_FREQ_400: qload = 8'(`TWM_QCNT(`TWM_KBPS_400) - 1);
      default: qload = 8'(`TWM_QCNT(`TWM_KBPS_1000) - 1);
    endcase
  end

  // A released SCL that still reads low is a slave stretching the clock
  assign stretch = scl_oe_n_o & ~scl_s2;
  assign tick = (qcnt == 8'h00) & ~stretch;
  assign busy = (state == twm_pkg::ST_START) || (state == twm_pkg::ST_BIT)
    || (state == twm_pkg::ST_HOLD);
  // Start is taken in idle, or between bytes once no memory access, stop or suspend is due
  assign take = (rd_p | wr_p) & ((state == twm_pkg::ST_IDLE) ||
    (state == twm_pkg::ST_HOLD && !dma_o.req && !rx_store && !stop_p
     && !susp_p));

  ////////////////////////////////////////////////////////////////////////////
  // Quarter period timer; stretch keeps it reloading
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) qcnt <= 8'h00;
    else if (tick || stretch || state == twm_pkg::ST_IDLE) qcnt <= qload;
    else qcnt <= qcnt - 8'h01;
  end

  // Pending tasks; a new task wins over the clear of the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_p <= 1'b0;
      wr_p <= 1'b0;
      stop_p <= 1'b0;
      susp_p <= 1'b0;
    end else begin
      rd_p <= (rd_p & ~take) | tk[`TWM_TK_RD];
      wr_p <= (wr_p & ~take) | tk[`TWM_TK_WR];
      // Stop is refused while suspended
      if (tk[`TWM_TK_STOP] && state != twm_pkg::ST_SUSP &&
          state != twm_pkg::ST_IDLE) stop_p <= 1'b1;
      else if (state == twm_pkg::ST_STOP) stop_p <= 1'b0;
      // Suspend only counts while a transfer is active
      if (tk[`TWM_TK_SUSP] && busy) susp_p <= 1'b1;
      else if (state == twm_pkg::ST_SUSP) susp_p <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, bus lines and buffer channels
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= twm_pkg::ST_IDLE;
      ph <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      is_rd <= 1'b0;
      addr_ph <= 1'b0;
      rx_store <= 1'b0;
      cnt <= 16'h0000;
      max_act <= 16'h0000;
      ptr_act <= `TWM_RST_WORD;
      ev_p <= 7'h00;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      dma_o <= '0;
      errsrc <= 3'h0;
      rx_amt <= 16'h0000;
      tx_amt <= 16'h0000;
    end else begin
      ev_p <= 7'h00;
      if (wr_en && paddr_i == `TWM_OFS_ERRSRC)
        errsrc <= errsrc & ~pwdata_i[2:0];
      if (take) begin
        // Shadow values move to the active set here only
        is_rd <= rd_p;
        cnt <= 16'h0000;
        ptr_act <= rd_p ? rx_ptr : tx_ptr;
        max_act <= rd_p ? rx_max : tx_max;
        ev_p[`TWM_EV_RXB] <= rd_p;
        ev_p[`TWM_EV_TXB] <= ~rd_p;
        state <= twm_pkg::ST_START;
        ph <= 2'h0;
      end else begin
        case (state)
          twm_pkg::ST_IDLE: begin
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
            if (tk[`TWM_TK_STOP]) ev_p[`TWM_EV_STOPPED] <= 1'b1;
          end
          twm_pkg::ST_START: if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) sda_oe_n_o <= 1'b1;
            else if (ph == 2'h1) scl_oe_n_o <= 1'b1;
            else if (ph == 2'h2) sda_oe_n_o <= 1'b0;
            else begin
              scl_oe_n_o <= 1'b0;
              shreg <= {saddr, is_rd};
              bitn <= 4'h0;
              addr_ph <= 1'b1;
              state <= twm_pkg::ST_BIT;
            end
          end
          twm_pkg::ST_BIT: if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
              if (bitn != 4'h8)
                sda_oe_n_o <= (is_rd && !addr_ph) ? 1'b1 : shreg[7];
              else if (is_rd && !addr_ph)
                sda_oe_n_o <= (cnt + 16'h0001 >= max_act);
              else
                sda_oe_n_o <= 1'b1;
            end else if (ph == 2'h1) begin
              scl_oe_n_o <= 1'b1;
            end else if (ph == 2'h2) begin
              if (bitn != 4'h8) shreg <= {shreg[6:0], sda_s2};
              else if ((addr_ph || !is_rd) && sda_s2) begin
                ev_p[`TWM_EV_ERROR] <= 1'b1;
                if (addr_ph) errsrc[`TWM_ERR_ANACK] <= 1'b1;
                else errsrc[`TWM_ERR_DNACK] <= 1'b1;
              end
            end else begin
              scl_oe_n_o <= 1'b0;
              if (bitn == 4'h8) begin
                // SDA kept past falling SCL; the next phase 0 sets it
                rx_store <= is_rd & ~addr_ph;
                addr_ph <= 1'b0;
                state <= twm_pkg::ST_HOLD;
              end else begin
                bitn <= bitn + 4'h1;
              end
            end
          end
          twm_pkg::ST_HOLD: begin
            // SCL stays low between bytes; bus waits on the controller
            if (dma_o.req) begin
              if (dma_ack_i) begin
                dma_o.req <= 1'b0;
                cnt <= cnt + 16'h0001;
                if (rx_store) begin
                  rx_store <= 1'b0;
                  rx_amt <= cnt + 16'h0001;
                end else begin
                  tx_amt <= cnt + 16'h0001;
                  shreg <= dma_rdata_i;
                  bitn <= 4'h0;
                  ph <= 2'h0;
                  state <= twm_pkg::ST_BIT;
                  if (cnt + 16'h0001 == max_act)
                    ev_p[`TWM_EV_LTX] <= 1'b1;
                end
              end
            end else if (rx_store) begin
              dma_o.req <= 1'b1;
              dma_o.we <= 1'b1;
              dma_o.addr <= ptr_act + {16'h0000, cnt};
              dma_o.wdata <= shreg;
            end else if (stop_p) begin
              ph <= 2'h0;
              state <= twm_pkg::ST_STOP;
            end else if (susp_p) begin
              ev_p[`TWM_EV_SUSP] <= 1'b1;
              state <= twm_pkg::ST_SUSP;
            end else if (cnt < max_act) begin
              // Buffer end leaves the bus held until a stop or a new start task
              if (!is_rd) begin
                dma_o.req <= 1'b1;
                dma_o.we <= 1'b0;
                dma_o.addr <= ptr_act + {16'h0000, cnt};
              end else begin
                if (cnt + 16'h0001 == max_act)
                  ev_p[`TWM_EV_LRX] <= 1'b1;
                bitn <= 4'h0;
                ph <= 2'h0;
                state <= twm_pkg::ST_BIT;
              end
            end
          end
          twm_pkg::ST_SUSP: begin
            scl_oe_n_o <= 1'b0;
            if (tk[`TWM_TK_RES]) state <= twm_pkg::ST_HOLD;
          end
          default: if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) sda_oe_n_o <= 1'b0;
            else if (ph == 2'h1) scl_oe_n_o <= 1'b1;
            else if (ph == 2'h2) sda_oe_n_o <= 1'b1;
            else begin
              // Memory is idle here: stores finish before stop is taken
              ev_p[`TWM_EV_STOPPED] <= 1'b1;
              state <= twm_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Event outputs are the one-cycle pulses
  assign event_o = ev_p;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags; write 0 clears, a new event wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evr <= 7'h00;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (ev_p[i]) evr[i] <= 1'b1;
        else if (wr_en && !pwdata_i[0] &&
          ((i == `TWM_EV_STOPPED && paddr_i == `TWM_OFS_EV_STOPPED) ||
           (i == `TWM_EV_ERROR && paddr_i == `TWM_OFS_EV_ERROR) ||
           (i == `TWM_EV_SUSP && paddr_i == `TWM_OFS_EV_SUSP) ||
           (i == `TWM_EV_RXB && paddr_i == `TWM_OFS_EV_RXB) ||
           (i == `TWM_EV_TXB && paddr_i == `TWM_OFS_EV_TXB) ||
           (i == `TWM_EV_LRX && paddr_i == `TWM_OFS_EV_LRX) ||
           (i == `TWM_EV_LTX && paddr_i == `TWM_OFS_EV_LTX)))
          evr[i] <= 1'b0;
      end
    end
  end

  // Configuration and shadow registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shorts <= 4'h0;
      enable <= 1'b0;
      freq <= `TWM_RST_FREQ;
      saddr <= 7'h00;
      rx_ptr <= `TWM_RST_WORD;
      tx_ptr <= `TWM_RST_WORD;
      rx_max <= 16'h0000;
      tx_max <= 16'h0000;
    end else if (wr_en) begin
      if (paddr_i == `TWM_OFS_SHORTS) shorts <= pwdata_i[3:0];
      else if (paddr_i == `TWM_OFS_ENABLE) enable <= pwdata_i[0];
      else if (paddr_i == `TWM_OFS_FREQ) freq <= pwdata_i[1:0];
      else if (paddr_i == `TWM_OFS_ADDR) saddr <= pwdata_i[6:0];
      else if (paddr_i == `TWM_OFS_RXPTR) rx_ptr <= pwdata_i;
      else if (paddr_i == `TWM_OFS_TXPTR) tx_ptr <= pwdata_i;
      else if (paddr_i == `TWM_OFS_RXMAX) rx_max <= pwdata_i[15:0];
      else if (paddr_i == `TWM_OFS_TXMAX) tx_max <= pwdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux and unmapped-address error
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr_i == `TWM_OFS_EV_STOPPED) next_rdata[0] = evr[`TWM_EV_STOPPED];
    else if (paddr_i == `TWM_OFS_EV_ERROR) next_rdata[0] = evr[`TWM_EV_ERROR];
    else if (paddr_i == `TWM_OFS_EV_SUSP) next_rdata[0] = evr[`TWM_EV_SUSP];
    else if (paddr_i == `TWM_OFS_EV_RXB) next_rdata[0] = evr[`TWM_EV_RXB];
    else if (paddr_i == `TWM_OFS_EV_TXB) next_rdata[0] = evr[`TWM_EV_TXB];
    else if (paddr_i == `TWM_OFS_EV_LRX) next_rdata[0] = evr[`TWM_EV_LRX];
    else if (paddr_i == `TWM_OFS_EV_LTX) next_rdata[0] = evr[`TWM_EV_LTX];
    else if (paddr_i == `TWM_OFS_SHORTS) next_rdata[3:0] = shorts;
    else if (paddr_i == `TWM_OFS_ERRSRC) next_rdata[2:0] = errsrc;
    else if (paddr_i == `TWM_OFS_ENABLE) next_rdata[0] = enable;
    else if (paddr_i == `TWM_OFS_FREQ) next_rdata[1:0] = freq;
    else if (paddr_i == `TWM_OFS_ADDR) next_rdata[6:0] = saddr;
    else if (paddr_i == `TWM_OFS_RXPTR) next_rdata = rx_ptr;
    else if (paddr_i == `TWM_OFS_TXPTR) next_rdata = tx_ptr;
    else if (paddr_i == `TWM_OFS_RXMAX) next_rdata[15:0] = rx_max;
    else if (paddr_i == `TWM_OFS_TXMAX) next_rdata[15:0] = tx_max;
    else if (paddr_i == `TWM_OFS_RXAMT) next_rdata[15:0] = rx_amt;
    else if (paddr_i == `TWM_OFS_TXAMT) next_rdata[15:0] = tx_amt;
    else if (paddr_i == `TWM_OFS_TASK_RD || paddr_i == `TWM_OFS_TASK_WR ||
      paddr_i == `TWM_OFS_TASK_STOP || paddr_i == `TWM_OFS_TASK_SUSP ||
      paddr_i == `TWM_OFS_TASK_RES) next_rdata = 32'h0000_0000;
    else next_err = 1'b1;
  end

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      prdata_o <= next_rdata;
      pslverr_o <= psel_i & ~penable_i & next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer
  stop_releases_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_p[`TWM_EV_STOPPED] && $past(state) == twm_pkg::ST_STOP |->
    sda_oe_n_o && scl_oe_n_o) else $error("stop not on bus");
  stop_dma_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_p[`TWM_EV_STOPPED] |-> !dma_o.req && !rx_store)
    else $error("stopped with memory busy");
  susp_scl_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state == twm_pkg::ST_SUSP ##1 state == twm_pkg::ST_SUSP |->
    !scl_oe_n_o) else $error("SCL released in suspend");
  nack_error_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state == twm_pkg::ST_BIT && tick && ph == 2'h2 && bitn == 4'h8 &&
    (addr_ph || !is_rd) && sda_s2 |=> ev_p[`TWM_EV_ERROR])
    else $error("NACK without error");
  start_cond_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state == twm_pkg::ST_START && tick && ph == 2'h2 |=>
    !sda_oe_n_o && scl_oe_n_o) else $error("bad start");
  dir_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state == twm_pkg::ST_START && tick && ph == 2'h3 |=>
    shreg == {saddr, is_rd} && state == twm_pkg::ST_BIT)
    else $error("bad address byte");
  rd_ack_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state == twm_pkg::ST_BIT && bitn == 4'h8 && ph == 2'h2 && is_rd &&
    !addr_ph |-> sda_oe_n_o == (cnt + 16'h0001 >= max_act))
    else $error("bad read acknowledge");
  last_tx_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_p[`TWM_EV_LTX] |-> state == twm_pkg::ST_BIT && bitn == 4'h0 &&
    cnt == max_act) else $error("final send misplaced");
  stretch_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state == twm_pkg::ST_BIT && ph == 2'h2 && scl_oe_n_o && !scl_s2 |=>
    ph == 2'h2) else $error("stretch ignored");
endmodule : twm_two_wire_master

// ==== verification/test_twm_two_wire_master.sv ====
// Self-checking bench of the two-wire master controller
`include "twm_defs.svh"
module test_twm_two_wire_master;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, dack = 0;
  logic str = 0, perr, prdy, erv, held;
  logic [11:0] pad = '0;
  logic [31:0] pwd = '0, prd, rdv;
  logic [4:0] tsk = '0;
  logic [6:0] ev, sadr = 7'h2a;
  logic [7:0] drd = '0;
  logic [7:0] mem [256];
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_low, sda_low, scl_w, sda_w;
  twm_pkg::twm_dma_s dma;
  int ev_n [7];
  int fail_count = 0, total_checks = 0, kb [4] = '{100, 250, 400, 1000};
  int s0, r0, per, q;
  time t0;
  always #5 mclk_i = ~mclk_i;
  // Open-drain lines with pull-ups
  assign scl_w = (scl_oe_n || scl_o) && !scl_low;
  assign sda_w = (sda_oe_n || sda_o) && !sda_low;
  twm_two_wire_master u_twm_two_wire_master (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .task_i(tsk), .event_o(ev),
    .dma_o(dma), .dma_rdata_i(drd), .dma_ack_i(dack), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n));
  twm_slave u_twm_slave (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(scl_low),
    .sda_low_o(sda_low), .addr_i(sadr), .stretch_i(str));
  ////////////////////////////////////////
  // Buffer memory acks one cycle after a request; events are tallied
  always @(posedge mclk_i) begin
    dack <= dma.req === 1 && !dack;
    drd <= mem[dma.addr[7:0]];
    if (dma.req === 1 && !dack && dma.we) mem[dma.addr[7:0]] <= dma.wdata;
    for (int i = 0; i < 7; i++) if (ev[i] === 1) ev_n[i]++;
  end
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One APB transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    {psel, pwr, pad, pwd} <= {1'b1, w, a, d};
    @(posedge mclk_i);
    pen <= 1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (prdy !== 1 && n < 20);
    {rdv, erv} = {prd, perr};
    {psel, pen} <= 2'b00;
    if (n == 20) chk("pready", 1, prdy);
  endtask : apb
  task automatic pulse(input int b);
    @(posedge mclk_i);
    tsk <= 5'h1 << b;
    @(posedge mclk_i);
    tsk <= '0;
  endtask : pulse
  // Bounded wait for an event tally
  task automatic wev(input int i, input int c);
    for (int n = 0; n < 99999 && ev_n[i] < c; n++) @(posedge mclk_i);
    chk("event count", c, ev_n[i]);
  endtask : wev
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h5a ^ i[7:0];
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1;
    chk("lines idle", 2'h3, {scl_oe_n, sda_oe_n});
    apb(0, `TWM_OFS_FREQ, 0);
    chk("freq reset", `TWM_RST_FREQ, rdv);
    apb(1, 12'hffc, 1);
    chk("unmapped", 1, erv);
    apb(1, `TWM_OFS_ENABLE, 1);
    apb(1, `TWM_OFS_ADDR, 7'h2a);
    apb(1, `TWM_OFS_SHORTS, 2);
    apb(1, `TWM_OFS_TXMAX, 1);
    // One-byte write at each rate, ended by the shortcut
    foreach (kb[i]) begin
      apb(1, `TWM_OFS_FREQ, i);
      pulse(`TWM_TK_WR);
      @(posedge scl_w);
      t0 = $time;
      @(posedge scl_w);
      per = int'(($time - t0) / 10);
      q = 100000 / (4 * kb[i]) * 4;
      chk("bit period", 1, per >= q && per <= q + 8);
      wev(`TWM_EV_STOPPED, i + 1);
    end
    wev(`TWM_EV_LTX, 4);
    chk("address ack", 1, u_twm_slave.hit);
    chk("write dir", 0, u_twm_slave.rd);
    chk("sent byte", mem[0], u_twm_slave.got[3]);
    // Suspend during the address byte, slave stretching
    str <= 1;
    apb(1, `TWM_OFS_TXMAX, 3);
    pulse(`TWM_TK_WR);
    wev(`TWM_EV_TXB, 5);
    apb(1, `TWM_OFS_TXPTR, 8'h80);
    @(posedge scl_w);
    pulse(`TWM_TK_SUSP);
    wev(`TWM_EV_SUSP, 1);
    held = 0;
    repeat (500) @(posedge mclk_i) held |= scl_w;
    chk("scl held", 0, held);
    pulse(`TWM_TK_STOP);
    repeat (300) @(posedge mclk_i);
    chk("stop in suspend", 4, ev_n[0]);
    s0 = u_twm_slave.stops;
    pulse(`TWM_TK_RES);
    wev(`TWM_EV_STOPPED, 5);
    chk("memory idle", 0, dma.req);
    chk("stop cond", 1, u_twm_slave.stops - s0);
    chk("last sent", mem[2], u_twm_slave.got[6]);
    // Reads of one and two bytes ended by the receive shortcut
    str <= 0;
    apb(1, `TWM_OFS_SHORTS, 8);
    apb(1, `TWM_OFS_RXPTR, 8'h40);
    for (int n = 1; n <= 2; n++) begin
      r0 = u_twm_slave.nr;
      apb(1, `TWM_OFS_RXMAX, n);
      apb(1, `TWM_OFS_TASK_RD, 1);
      wev(`TWM_EV_STOPPED, 5 + n);
      wev(`TWM_EV_LRX, n);
      chk("read dir", 1, u_twm_slave.rd);
      chk("read byte", 8'hc3 ^ (r0 + n - 1), mem[8'h3f + n]);
      chk("last nack", 1, u_twm_slave.mack[r0 + n - 1]);
    end
    chk("ack", 0, u_twm_slave.mack[1]);
    // Refused address: error, no stop until asked
    sadr <= 7'h15;
    pulse(`TWM_TK_WR);
    wev(`TWM_EV_ERROR, 1);
    repeat (300) @(posedge mclk_i);
    chk("own stop", 7, ev_n[0]);
    apb(0, `TWM_OFS_ERRSRC, 0);
    chk("error source", 32'h2, rdv);
    pulse(`TWM_TK_STOP);
    wev(`TWM_EV_STOPPED, 8);
    // Write then read joined by a repeated start
    sadr <= 7'h2a;
    apb(1, `TWM_OFS_SHORTS, 9);
    apb(1, `TWM_OFS_TXMAX, 1);
    apb(1, `TWM_OFS_RXMAX, 1);
    s0 = u_twm_slave.starts;
    pulse(`TWM_TK_WR);
    wev(`TWM_EV_STOPPED, 9);
    chk("starts", 2, u_twm_slave.starts - s0);
    chk("written", mem[8'h80], u_twm_slave.got[7]);
    end_of_test();
  end
  // Watchdog beyond the longest expected run
  initial begin
    #900000;
    fail_count++;
    end_of_test();
  end
endmodule : test_twm_two_wire_master

// ==== verification/twm_slave.sv ====
// Behavioural two-wire slave that logs bytes and stretches the clock
module twm_slave (
  // Bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o,
  // Test controls
  input wire logic [6:0] addr_i,
  input wire logic stretch_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int bits = 0, nw = 0, nr = 0, starts = 0, stops = 0;
  logic [7:0] sh, tx;
  logic [7:0] got [16];
  logic mack [16];
  logic adr = 0, rd = 0, hit = 0;
  initial {scl_low_o, sda_low_o} = 2'b00;
  ////////////////////////////////////////
  // Start and stop conditions, SCL high
  always @(negedge sda_i) if (scl_i) begin
    {bits, adr} = {32'h0, 1'b1};
    starts++;
  end
  always @(posedge sda_i) if (scl_i) stops++;
  // Sample data and master acknowledge
  always @(posedge scl_i) begin
    if (bits < 8) sh = {sh[6:0], sda_i};
    else if (rd && !adr) mack[nr - 1] = sda_i;
    bits++;
  end
  // Drive after the falling clock edge only
  always @(negedge scl_i) begin
    sda_low_o = 0;
    if (bits == 8 && adr) begin
      hit = sh[7:1] == addr_i;
      rd = sh[0];
      sda_low_o = hit;
    end else if (bits == 8 && hit && !rd) begin
      got[nw] = sh;
      nw++;
      sda_low_o = 1;
    end else if (bits == 9) begin
      bits = 0;
      if (hit && rd && (adr || !mack[nr - 1])) begin
        tx = 8'hc3 ^ nr[7:0];
        nr++;
        sda_low_o = !tx[7];
      end
      adr = 0;
      // Long enough to show the master waits
      if (stretch_i) begin
        scl_low_o = 1;
        #3000 scl_low_o = 0;
      end
    end else if (hit && rd && !adr && bits > 0 && bits < 8) begin
      // Ack slot of a read is left to the master
      sda_low_o = !tx[7 - bits];
    end
  end
endmodule : twm_slave
